//--- core/smbus_status_control_map.vh
// Register map, field positions, reset values and timing counts for the
// SMBus status and control block. Included by bare name; no logic here.
`ifndef SMBUS_STATUS_CONTROL_MAP_VH
`define SMBUS_STATUS_CONTROL_MAP_VH

// Byte addresses on the register bus
`define STATUS_ADDR 16'h1188
`define CONTROL_ADDR 16'h118c
`define IRQ_ENABLE_ADDR 16'h1194
`define IRQ_CLEAR_ADDR 16'h1198

// Status bit positions
`define LOAD_ERROR_BIT 20
`define BAD_BLOCK_BIT 21
`define BLANK_BIT 22
`define ROLLOVER_BIT 23
`define LOAD_FINISHED_BIT 24
`define NO_ACK_BIT 25
`define MISC_FAULT_BIT 27
`define CHECKSUM_FAULT_BIT 28
`define UNMAPPED_BIT 29
`define WAIT_EXPIRED_BIT 31
`define STATUS_W1C_MASK 32'hbbf00000

// Control field positions
`define DIVIDER_LSB 0
`define DIVIDER_MSB 15
`define IO_MODE_BIT 16
`define SKIP_SUM_BIT 17
`define SLAVE_MODE_LSB 18
`define MASTER_MODE_LSB 20
`define TIMEOUT_OFF_BIT 22
`define WAIT_LIMIT_LSB 23
`define CONTROL_RW_MASK 32'h03ffffff
`define CONTROL_RESET 32'h00000053

// Timing: base unit of the divider, filter delays and wait block limits
`define CLK_PERIOD_NS 4
`define DIVIDER_UNIT_NS 32
`define DIVIDER_UNIT_CYCLES (`DIVIDER_UNIT_NS / `CLK_PERIOD_NS)
`define FILTER_SLOW_NS 1000
`define FILTER_FAST_NS 100
`define FILTER_SLOW_CYCLES (`FILTER_SLOW_NS / `CLK_PERIOD_NS)
`define FILTER_FAST_CYCLES (`FILTER_FAST_NS / `CLK_PERIOD_NS)
`define WAIT_1US_NS 1000
`define WAIT_5US_NS 5000
`define WAIT_10MS_NS 10000000
`define WAIT_100MS_NS 100000000
`define WAIT_1US_CYCLES (`WAIT_1US_NS / `CLK_PERIOD_NS)
`define WAIT_5US_CYCLES (`WAIT_5US_NS / `CLK_PERIOD_NS)
`define WAIT_10MS_CYCLES (`WAIT_10MS_NS / `CLK_PERIOD_NS)
`define WAIT_100MS_CYCLES (`WAIT_100MS_NS / `CLK_PERIOD_NS)

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- core/smbus_status_control.v
// SMBus status flags and control settings with an AXI4-Lite slave.
// Assumes the loader and master bus engine report events as one-cycle
// pulses on sys_clk; bus pins are asynchronous and synchronised here.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "smbus_status_control_map.vh"

module smbus_status_control #(
   parameter WAIT_10MS = `WAIT_10MS_CYCLES,
   parameter WAIT_100MS = `WAIT_100MS_CYCLES
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // AXI4-Lite write
   input wire [15:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [15:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Loader and master engine events, one-cycle pulses; load_active and wait_block_active are levels
   input wire bad_block_event,
   input wire blank_event,
   input wire rollover_event,
   input wire load_end_event,
   input wire no_ack_event,
   input wire misc_fault_event,
   input wire sum_mismatch_event,
   input wire missing_done_event,
   input wire unmapped_event,
   input wire unknown_error_event,
   input wire load_active,
   input wire wait_block_active,
   // Read-only address fields
   input wire [6:0] slave_address,
   input wire [6:0] master_address,
   // Bus pins, asynchronous
   input wire slave_bus_clock_pin,
   input wire slave_bus_data_pin,
   input wire master_bus_clock_pin,
   input wire master_bus_data_pin,
   // Filtered pins and timing base
   output wire slave_clock_filtered,
   output wire slave_data_filtered,
   output wire master_clock_filtered,
   output wire master_data_filtered,
   output reg master_tick,
   // Control outputs
   output reg load_abort,
   output reg reset_hold,
   output wire skip_sum_check,
   output wire defeatured_io_mode,
   output wire timeout_disable,
   output wire irq
);

   reg [31:0] status;
   reg [31:0] control;
   reg [31:0] irq_enable;
   reg [31:0] next_status;
   reg aw_held;
   reg w_held;
   reg [15:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [15:0] div_count;
   reg [2:0] unit_count;
   reg [24:0] wait_count;
   reg [24:0] wait_limit_cycles;
   reg wait_expired;

   // Timing counts cut to the widths of the counters that compare them
   localparam [31:0] UNIT_LAST = `DIVIDER_UNIT_CYCLES - 1;
   localparam [31:0] WAIT_1US = `WAIT_1US_CYCLES;
   localparam [31:0] WAIT_5US = `WAIT_5US_CYCLES;

   wire [15:0] master_clock_divider = control[`DIVIDER_MSB:`DIVIDER_LSB];
   wire [1:0] slave_filter_mode = control[`SLAVE_MODE_LSB+1:`SLAVE_MODE_LSB];
   wire [1:0] master_filter_mode =
      control[`MASTER_MODE_LSB+1:`MASTER_MODE_LSB];
   wire [2:0] wait_block_limit = control[`WAIT_LIMIT_LSB+2:`WAIT_LIMIT_LSB];

   assign skip_sum_check = control[`SKIP_SUM_BIT];
   assign defeatured_io_mode = control[`IO_MODE_BIT];
   assign timeout_disable = control[`TIMEOUT_OFF_BIT];
   assign irq = |(status & irq_enable & `STATUS_W1C_MASK);

   // Write channels are taken in either order; response follows both
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire aw_now = aw_held | (s_axi_awvalid & s_axi_awready);
   wire w_now = w_held | (s_axi_wvalid & s_axi_wready);
   wire [15:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
   wire wr_fire = aw_now & w_now & ~s_axi_bvalid;
   wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                          {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire wr_status = wr_fire & (wr_addr == `STATUS_ADDR);
   wire wr_clear = wr_fire & (wr_addr == `IRQ_CLEAR_ADDR);
   wire [31:0] clear_bits = (wr_status | wr_clear) ?
      (wr_data & wr_mask & `STATUS_W1C_MASK) : 32'h00000000;

   // Checksum fault: a bad sum is ignored when skipping, a missing
   // done block is still a fault
   wire sum_fault = (sum_mismatch_event & ~skip_sum_check)
                    | missing_done_event;
   // Error events abort the load and set the general error flag
   wire load_error = bad_block_event | rollover_event | no_ack_event
                     | misc_fault_event | sum_fault | wait_expired
                     | unknown_error_event;

   always @* begin
      next_status = status & ~clear_bits;
      // Sets are applied after the clear, so a set wins
      if (bad_block_event) next_status[`BAD_BLOCK_BIT] = 1'b1;
      if (blank_event) next_status[`BLANK_BIT] = 1'b1;
      if (rollover_event) next_status[`ROLLOVER_BIT] = 1'b1;
      if (load_end_event | load_error)
         next_status[`LOAD_FINISHED_BIT] = 1'b1;
      if (no_ack_event) next_status[`NO_ACK_BIT] = 1'b1;
      if (misc_fault_event) next_status[`MISC_FAULT_BIT] = 1'b1;
      if (sum_fault) next_status[`CHECKSUM_FAULT_BIT] = 1'b1;
      if (unmapped_event) next_status[`UNMAPPED_BIT] = 1'b1;
      if (wait_expired) next_status[`WAIT_EXPIRED_BIT] = 1'b1;
      if (load_error) next_status[`LOAD_ERROR_BIT] = 1'b1;
   end

   // Register state; the only reset is fundamental, so flags survive
   // any soft reset handled elsewhere
   always @(posedge sys_clk) begin
      if (rst) begin
         status <= 32'h00000000;
         control <= `CONTROL_RESET;
         irq_enable <= 32'h00000000;
         load_abort <= 1'b0;
         reset_hold <= 1'b0;
      end else begin
         status <= next_status;
         if (load_error) begin
            load_abort <= 1'b1;
            reset_hold <= 1'b1;
         end else begin
            load_abort <= 1'b0;
         end
         if (wr_fire & (wr_addr == `CONTROL_ADDR))
            control <= (control & ~(wr_mask & `CONTROL_RW_MASK))
                       | (wr_data & wr_mask & `CONTROL_RW_MASK);
         if (wr_fire & (wr_addr == `IRQ_ENABLE_ADDR))
            irq_enable <= (irq_enable & ~wr_mask)
                          | (wr_data & wr_mask & `STATUS_W1C_MASK);
      end
   end

   // AXI4-Lite write handshake
   always @(posedge sys_clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 16'h0000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if ((wr_addr == `STATUS_ADDR) | (wr_addr == `CONTROL_ADDR) |
                (wr_addr == `IRQ_ENABLE_ADDR) |
                (wr_addr == `IRQ_CLEAR_ADDR))
               s_axi_bresp <= `RESP_OKAY;
            else
               s_axi_bresp <= `RESP_SLVERR;
         end else begin
            if (s_axi_awvalid & s_axi_awready) begin
               aw_held <= 1'b1;
               aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata;
               w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read
   always @(posedge sys_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case (s_axi_araddr)
            `STATUS_ADDR: s_axi_rdata <= (status & `STATUS_W1C_MASK)
               | {16'h0000, master_address, 1'b0, slave_address, 1'b0};
            `CONTROL_ADDR: s_axi_rdata <= control;
            `IRQ_ENABLE_ADDR: s_axi_rdata <= irq_enable;
            `IRQ_CLEAR_ADDR: s_axi_rdata <= 32'h00000000;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Master timing base: one tick per divider units of 32 ns, no tick for a divider below 2
   always @(posedge sys_clk) begin
      if (rst) begin
         unit_count <= 3'h0;
         div_count <= 16'h0000;
         master_tick <= 1'b0;
      end else if (master_clock_divider < 16'h0002) begin
         unit_count <= 3'h0;
         div_count <= 16'h0000;
         master_tick <= 1'b0;
      end else begin
         master_tick <= 1'b0;
         if (unit_count == UNIT_LAST[2:0]) begin
            unit_count <= 3'h0;
            if (div_count >= master_clock_divider - 16'h0001) begin
               div_count <= 16'h0000;
               master_tick <= 1'b1;
            end else begin
               div_count <= div_count + 16'h0001;
            end
         end else begin
            unit_count <= unit_count + 3'h1;
         end
      end
   end

   // Wait block timeout
   always @* begin
      case (wait_block_limit)
         3'h1: wait_limit_cycles = WAIT_1US[24:0];
         3'h2: wait_limit_cycles = WAIT_5US[24:0];
         3'h3: wait_limit_cycles = WAIT_10MS[24:0];
         3'h4: wait_limit_cycles = WAIT_100MS[24:0];
         default: wait_limit_cycles = 25'h0000000;
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         wait_count <= 25'h0000000;
         wait_expired <= 1'b0;
      end else begin
         wait_expired <= 1'b0;
         if (~wait_block_active | ~load_active) begin
            wait_count <= 25'h0000000;
         end else if (wait_limit_cycles != 25'h0000000) begin
            if (wait_count == wait_limit_cycles - 25'h0000001)
               wait_expired <= 1'b1;
            if (wait_count != wait_limit_cycles)
               wait_count <= wait_count + 25'h0000001;
         end
      end
   end

   // Pin glitch filters
   glitch_filter slave_clock_filter (
      .sys_clk(sys_clk), .rst(rst), .mode(slave_filter_mode),
      .pin(slave_bus_clock_pin), .filtered(slave_clock_filtered)
   );
   glitch_filter slave_data_filter (
      .sys_clk(sys_clk), .rst(rst), .mode(slave_filter_mode),
      .pin(slave_bus_data_pin), .filtered(slave_data_filtered)
   );
   glitch_filter master_clock_filter (
      .sys_clk(sys_clk), .rst(rst), .mode(master_filter_mode),
      .pin(master_bus_clock_pin), .filtered(master_clock_filtered)
   );
   glitch_filter master_data_filter (
      .sys_clk(sys_clk), .rst(rst), .mode(master_filter_mode),
      .pin(master_bus_data_pin), .filtered(master_data_filtered)
   );

endmodule

// Synchroniser plus glitch counter: output follows the pin once it has
// been stable for the selected number of cycles
module glitch_filter (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Delay select and pin
   input wire [1:0] mode,
   input wire pin,
   output reg filtered
);

   reg sync_a;
   reg sync_b;
   reg [7:0] count;
   reg [7:0] limit;

   // Filter lengths in cycles, cut to the counter width
   localparam [31:0] SLOW_LIMIT = `FILTER_SLOW_CYCLES;
   localparam [31:0] FAST_LIMIT = `FILTER_FAST_CYCLES;

   always @* begin
      case (mode)
         2'h0: limit = SLOW_LIMIT[7:0];
         2'h1: limit = FAST_LIMIT[7:0];
         default: limit = 8'h00; // reserved treated as no filter
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         count <= 8'h00;
         filtered <= 1'b1;
      end else begin
         sync_a <= pin;
         sync_b <= sync_a;
         if (sync_b == filtered) begin
            count <= 8'h00;
         end else if (count >= limit) begin
            filtered <= sync_b;
            count <= 8'h00;
         end else begin
            count <= count + 8'h01;
         end
      end
   end

endmodule

//--- sim/smbus_status_control_props.sv
// Checker of the SMBus status and control block, on its ports only.
// Assumes sys_clk alone and a synchronous active-high rst.
module smbus_status_control_props (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // Events
   input wire bad_block_event,
   input wire rollover_event,
   input wire no_ack_event,
   input wire misc_fault_event,
   input wire sum_mismatch_event,
   input wire missing_done_event,
   input wire unknown_error_event,
   input wire wait_block_active,
   // Outputs watched
   input wire master_tick,
   input wire load_abort,
   input wire reset_hold,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire err = bad_block_event | rollover_event | no_ack_event |
      misc_fault_event | missing_done_event | unknown_error_event;
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write response missing");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   a_rdata_stands: assert property (
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_busy_refuse: assert property (
      s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");
   a_abort_on_err: assert property (err |=> load_abort)
      else $error("load not aborted");
   a_hold_on_err: assert property (err |-> ##[1:2] reset_hold)
      else $error("reset hold not set");
   a_hold_sticks: assert property (reset_hold |=> reset_hold)
      else $error("reset hold dropped");
   a_quiet_no_abort: assert property (
      !err && !sum_mismatch_event && !wait_block_active &&
      !$past(wait_block_active) && !$past(wait_block_active, 2)
      |=> !load_abort) else $error("abort without error");
   a_tick_gap: assert property (master_tick |=> !master_tick[*8])
      else $error("ticks too close");
   c_irq: cover property (irq);
   c_abort: cover property (load_abort);
   c_tick: cover property (master_tick);
endmodule

//--- sim/far_side_model.sv
// Loader, master engine and bus pins as seen by the block.
// Assumes the bench calls its tasks just after a rising sys_clk edge.
module far_side_model (
   // Clock
   input wire sys_clk,
   // Event pulses in the block's port order; pins sclk, sdat, mclk, mdat
   output logic [9:0] ev,
   output logic [3:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ev = '0;
      pin = 4'hf;
   end
   task pulse(input int i);
      begin
         @(posedge sys_clk);
         ev[i] <= 1'b1;
         @(posedge sys_clk);
         ev <= '0;
         // Return once the flag it set is visible
         @(posedge sys_clk);
      end
   endtask
   // Pins idle high under pull-ups; a flip moves all four
   task flip;
      begin
         @(posedge sys_clk);
         pin <= ~pin;
      end
   endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench of the SMBus status and control block.
// Assumes the far side model for events and pins; 250 MHz sys_clk.
`include "smbus_status_control_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, load_active, wait_block_active;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, master_tick, load_abort, reset_hold, irq;
   logic skip_sum_check, defeatured_io_mode, timeout_disable;
   logic slave_clock_filtered, slave_data_filtered;
   logic master_clock_filtered, master_data_filtered;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [9:0] ev;
   logic [6:0] slave_address, master_address;
   logic [3:0] s_axi_wstrb;
   logic [3:0] pin;
   int err_count, n_compared, n;
   localparam logic [31:0] ab = 32'h00002a54;
   localparam logic [31:0] fl [10] = '{32'h01300000, 32'h00400000,
      32'h01900000, 32'h01000000, 32'h03100000, 32'h09100000,
      32'h11100000, 32'h11100000, 32'h20000000, 32'h01100000};
   localparam int wl [5] = '{0, 250, 1250, 40, 80};
   localparam int dv [4] = '{2, 5, 1, 0};
   localparam int fw [4] = '{250, 25, 0, 0};
   wire [3:0] filt = {master_data_filtered, master_clock_filtered,
      slave_data_filtered, slave_clock_filtered};
   smbus_status_control #(.WAIT_10MS(40), .WAIT_100MS(80)) DUT (
      .sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .bad_block_event(ev[0]),
      .blank_event(ev[1]), .rollover_event(ev[2]),
      .load_end_event(ev[3]), .no_ack_event(ev[4]),
      .misc_fault_event(ev[5]), .sum_mismatch_event(ev[6]),
      .missing_done_event(ev[7]), .unmapped_event(ev[8]),
      .unknown_error_event(ev[9]), .load_active, .wait_block_active,
      .slave_address, .master_address,
      .slave_bus_clock_pin(pin[0]), .slave_bus_data_pin(pin[1]),
      .master_bus_clock_pin(pin[2]), .master_bus_data_pin(pin[3]),
      .slave_clock_filtered, .slave_data_filtered, .master_clock_filtered,
      .master_data_filtered, .master_tick, .load_abort, .reset_hold,
      .skip_sum_check, .defeatured_io_mode, .timeout_disable, .irq);
   far_side_model fs (.sys_clk(sys_clk), .ev(ev), .pin(pin));
   always #2 sys_clk = ~sys_clk;
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         n_compared++;
         if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input logic [15:0] a, input logic [31:0] v);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge sys_clk);
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
         end while (s_axi_awvalid && !s_axi_awready ||
            s_axi_wvalid && !s_axi_wready);
         while (s_axi_bvalid !== 1'b1)
            @(posedge sys_clk);
         r = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   // Ready is raised late so that read data must stand a cycle
   task rd(input logic [15:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do
            @(posedge sys_clk);
         while (s_axi_arready !== 1'b1);
         s_axi_arvalid <= 1'b0;
         while (s_axi_rvalid !== 1'b1)
            @(posedge sys_clk);
         s_axi_rready <= 1'b1;
         @(posedge sys_clk);
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task tgap;
      begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (master_tick !== 1'b1 && n < 200);
      end
   endtask
   task tally_and_finish;
      begin
         $display("compared %0d mismatches %0d", n_compared, err_count);
         if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      tally_and_finish;
   end
   initial begin
      {sys_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, load_active, wait_block_active} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {slave_address, master_address} = {7'h2a, 7'h15};
      rst = 1'b1;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`STATUS_ADDR);
      chk("status reset", ab, d);
      slave_address <= 7'h55;
      rd(`STATUS_ADDR);
      chk("address fields", 32'h00002aaa, d);
      slave_address <= 7'h2a;
      wr(`CONTROL_ADDR, 32'hfc000053);
      chk("write resp", `RESP_OKAY, r);
      rd(`CONTROL_ADDR);
      chk("control", `CONTROL_RESET, d);
      s_axi_wstrb <= 4'h1;
      wr(`CONTROL_ADDR, 32'h03ffffaa);
      s_axi_wstrb <= 4'hf;
      rd(`CONTROL_ADDR);
      chk("byte lanes", 32'h000000aa, d);
      rd(16'h1000);
      chk("unmapped resp", `RESP_SLVERR, r);
      wr(16'h1000, 32'h00000000);
      chk("unmapped write", `RESP_SLVERR, r);
      for (int i = 0; i < 10; i++) begin
         fs.pulse(i);
         wr(`STATUS_ADDR, 32'h0);
         rd(`STATUS_ADDR);
         chk("status", fl[i] | ab, d);
         wr(`IRQ_CLEAR_ADDR, 32'hffffffff);
         rd(`STATUS_ADDR);
         chk("cleared", ab, d);
      end
      chk("reset hold", 1, reset_hold);
      wr(`CONTROL_ADDR, 32'h00020053);
      chk("control outs", 32'h4, {skip_sum_check, defeatured_io_mode,
         timeout_disable});
      fs.pulse(6);
      rd(`STATUS_ADDR);
      chk("skip sum", ab, d);
      wr(`IRQ_ENABLE_ADDR, 32'h02000000);
      fs.pulse(4);
      chk("irq on", 1, irq);
      wr(`IRQ_CLEAR_ADDR, 32'hffffffff);
      chk("irq off", 0, irq);
      wr(`IRQ_ENABLE_ADDR, 32'h80000000);
      fs.pulse(4);
      chk("irq masked", 0, irq);
      for (int k = 0; k < 5; k++) begin
         wr(`CONTROL_ADDR, 32'h53 | (k << 23));
         wr(`IRQ_CLEAR_ADDR, 32'hffffffff);
         load_active <= 1'b1;
         wait_block_active <= 1'b1;
         n = 0;
         while (irq !== 1'b1 && n < 1400) begin
            @(posedge sys_clk);
            n++;
         end
         chk("wait", 1, 32'(k ? n >= wl[k] - 2 && n <= wl[k] + 4 :
            n == 1400));
         load_active <= 1'b0;
         wait_block_active <= 1'b0;
         @(posedge sys_clk);
      end
      for (int k = 0; k < 4; k++) begin
         wr(`CONTROL_ADDR, dv[k]);
         tgap;
         tgap;
         chk("tick gap", dv[k] < 2 ? 200 : 8 * dv[k], n);
      end
      for (int m = 0; m < 4; m++) begin
         wr(`CONTROL_ADDR, 32'h53 | (m << 18) | (m << 20));
         fs.flip;
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (filt !== pin && n < 400);
         chk("filter", 1, 32'(n > fw[m] && n < fw[m] + 8));
      end
      tally_and_finish;
   end
endmodule
bind smbus_status_control smbus_status_control_props props_i (
   .sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .bad_block_event,
   .rollover_event, .no_ack_event, .misc_fault_event, .sum_mismatch_event,
   .missing_done_event, .unknown_error_event, .wait_block_active,
   .master_tick, .load_abort, .reset_hold, .irq);
